// ---- design/dcipm_top.sv ----
// top: per-channel interrupt mask/status and two-monitor performance counters behind avalon-mm
//////////////////////////////////////////////////////////////////////////////
// How it works
// - enable write ones set mask bits
// - disable write ones clear mask bits
// - mask resets zero, one enables source
// - error flag sticky until clear command
// - complete flag when both counters zero
// - reload-zero flag when reload counter zero
// - select fields pick monitored dma channel
// - monitor 1 reset bit, reads zero
// - monitor 0 reset bit, reads zero
// - freeze off: overflow resets monitor registers
// - freeze on: hold just before overflow
// - monitor 1 enable bit gates counting
// - monitor 0 enable bit gates counting
//////////////////////////////////////////////////////////////////////////////
module dcipm_top #(
    parameter int unsigned NUM_CH = 4,
    parameter int unsigned CNT_W = 32
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire dcipm_pkg::dcipm_avs_req_t avs_req_i,
    input wire logic [NUM_CH-1:0] xfer_error_i,
    input wire logic [NUM_CH-1:0] error_clear_cmd_i,
    input wire logic [NUM_CH-1:0] xfer_counter_zero_i,
    input wire logic [NUM_CH-1:0] xfer_counter_reload_zero_i,
    input wire logic [NUM_CH-1:0] data_cycle_i,
    input wire logic [NUM_CH-1:0] stall_cycle_i,
    output logic avs_waitrequest_o,
    output logic [31:0] avs_readdata_o,
    output logic [NUM_CH-1:0] irq_o,
    output logic [1:0][CNT_W-1:0] mon_data_o,
    output logic [1:0][CNT_W-1:0] mon_stall_o
);
    import dcipm_pkg::*;

    typedef struct packed {
        logic waitreq;
        logic [31:0] rdata;
        logic [NUM_CH-1:0][2:0] mask;
        logic [NUM_CH-1:0] err;
        logic [NUM_CH-1:0] irq;
        logic [1:0][SEL_W-1:0] sel;
        logic [1:0] frz;
        logic [1:0] en;
        logic [1:0][CNT_W-1:0] data;
        logic [1:0][CNT_W-1:0] stall;
    } dcipm_state_t;

    dcipm_state_t state_ff;
    dcipm_state_t nxt_state;
    logic [NUM_CH-1:0][2:0] stat;
    logic wr_go;
    logic rd_take;
    logic [1:0] res_wr;
    logic [1:0] hit_d;
    logic [1:0] hit_s;
    logic [1:0] ovf;
    logic [63:0] dvec;
    logic [63:0] svec;

    // true when the address names register ofs of channel c
    function automatic logic ch_hit(input logic [ADDR_W-1:0] a, input logic [5:0] ofs, input int c);
        ch_hit = !a[ADDR_W-1] && (a[5:0] == ofs) && (int'(a[ADDR_W-2:CH_SHIFT]) == c);
    endfunction

    //////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        nxt_state = state_ff;
        // write lands at the edge where waitrequest is seen low
        wr_go = avs_req_i.write && !state_ff.waitreq;
        // read data is captured one edge before it is handed over
        rd_take = avs_req_i.read && state_ff.waitreq;
        // one wait cycle per access keeps read data straight from a flop
        nxt_state.waitreq = !((avs_req_i.read || avs_req_i.write) && state_ff.waitreq);

        // live status per channel
        for (int c = 0; c < NUM_CH; c++) begin
            stat[c][BIT_ERROR] = state_ff.err[c];
            stat[c][BIT_COMPLETE] = xfer_counter_zero_i[c] && xfer_counter_reload_zero_i[c];
            stat[c][BIT_RELOAD_ZERO] = xfer_counter_reload_zero_i[c];
        end

        // sticky error, a new error beats a clear in the same cycle
        for (int c = 0; c < NUM_CH; c++) begin
            if (xfer_error_i[c]) begin
                nxt_state.err[c] = 1'b1;
            end else if (error_clear_cmd_i[c]) begin
                nxt_state.err[c] = 1'b0;
            end
        end

        // mask set/clear, only byte lane 0 carries bits
        for (int c = 0; c < NUM_CH; c++) begin
            if (wr_go && avs_req_i.byteenable[0]) begin
                if (ch_hit(avs_req_i.address, OFS_IRQ_EN, c)) begin
                    nxt_state.mask[c] = state_ff.mask[c] | avs_req_i.writedata[2:0];
                end else if (ch_hit(avs_req_i.address, OFS_IRQ_DIS, c)) begin
                    nxt_state.mask[c] = state_ff.mask[c] & ~avs_req_i.writedata[2:0];
                end
            end
            // registered, so irq lags status by one cycle
            nxt_state.irq[c] = |(stat[c] & state_ff.mask[c]);
        end

        // perf control write, per byte lane
        res_wr = 2'b00;
        if (wr_go && avs_req_i.address == OFS_PCTL) begin
            if (avs_req_i.byteenable[0]) begin
                nxt_state.en[0] = avs_req_i.writedata[PC_EN0];
                nxt_state.en[1] = avs_req_i.writedata[PC_EN1];
                nxt_state.frz[0] = avs_req_i.writedata[PC_OF0];
                nxt_state.frz[1] = avs_req_i.writedata[PC_OF1];
            end
            if (avs_req_i.byteenable[1]) begin
                res_wr[0] = avs_req_i.writedata[PC_RES0];
                res_wr[1] = avs_req_i.writedata[PC_RES1];
            end
            if (avs_req_i.byteenable[2]) begin
                nxt_state.sel[0] = avs_req_i.writedata[PC_SEL0 +: SEL_W];
            end
            if (avs_req_i.byteenable[3]) begin
                nxt_state.sel[1] = avs_req_i.writedata[PC_SEL1 +: SEL_W];
            end
        end

        // monitors; a select beyond the channel count sees no traffic
        dvec = 64'(data_cycle_i);
        svec = 64'(stall_cycle_i);
        for (int m = 0; m < 2; m++) begin
            hit_d[m] = state_ff.en[m] && dvec[state_ff.sel[m]];
            hit_s[m] = state_ff.en[m] && svec[state_ff.sel[m]];
            ovf[m] = (hit_d[m] && &state_ff.data[m]) || (hit_s[m] && &state_ff.stall[m]);
            if (res_wr[m]) begin
                nxt_state.data[m] = '0;
                nxt_state.stall[m] = '0;
            end else if (ovf[m]) begin
                if (!state_ff.frz[m]) begin
                    nxt_state.data[m] = '0;
                    nxt_state.stall[m] = '0;
                end
                // freeze: both counters keep their value
            end else begin
                nxt_state.data[m] = state_ff.data[m] + CNT_W'(hit_d[m]);
                nxt_state.stall[m] = state_ff.stall[m] + CNT_W'(hit_s[m]);
            end
        end

        // read mux, unmapped and write-only words read zero
        nxt_state.rdata = RDATA_IDLE;
        if (rd_take) begin
            if (avs_req_i.address == OFS_PCTL) begin
                nxt_state.rdata[PC_EN0] = state_ff.en[0];
                nxt_state.rdata[PC_EN1] = state_ff.en[1];
                nxt_state.rdata[PC_OF0] = state_ff.frz[0];
                nxt_state.rdata[PC_OF1] = state_ff.frz[1];
                nxt_state.rdata[PC_SEL0 +: SEL_W] = state_ff.sel[0];
                nxt_state.rdata[PC_SEL1 +: SEL_W] = state_ff.sel[1];
                // reset bits are never stored, so they read zero
            end else begin
                for (int c = 0; c < NUM_CH; c++) begin
                    if (ch_hit(avs_req_i.address, OFS_IRQ_MASK, c)) begin
                        nxt_state.rdata[2:0] = state_ff.mask[c];
                    end else if (ch_hit(avs_req_i.address, OFS_IRQ_STAT, c)) begin
                        nxt_state.rdata[2:0] = stat[c];
                    end
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_ff <= '0;
            state_ff.waitreq <= 1'b1;
            state_ff.rdata <= RDATA_IDLE;
            for (int c = 0; c < NUM_CH; c++) begin
                state_ff.mask[c] <= MASK_RST;
            end
            state_ff.sel[0] <= PCTL_RST[PC_SEL0 +: SEL_W];
            state_ff.sel[1] <= PCTL_RST[PC_SEL1 +: SEL_W];
        end else begin
            state_ff <= nxt_state;
        end
    end

    // outputs straight from the state flops
    assign avs_waitrequest_o = state_ff.waitreq;
    assign avs_readdata_o = state_ff.rdata;
    assign irq_o = state_ff.irq;
    assign mon_data_o = state_ff.data;
    assign mon_stall_o = state_ff.stall;

    //////////////////////////////////////////////////////////////////////////////
    // checks on channels 0 to 2 and both monitors; each watches a channel that really sees traffic, except channel 0, which sees only bus accesses
    sequence s_wr(logic [5:0] ofs, int b);
        wr_go && avs_req_i.byteenable[0] && ch_hit(avs_req_i.address, ofs, 0) && avs_req_i.writedata[b];
    endsequence

    sequence s_rd_stat;
        rd_take && ch_hit(avs_req_i.address, OFS_IRQ_STAT, 0);
    endsequence

    // one wait cycle, then waitrequest is back high for the next access
    sequence s_answer;
        !state_ff.waitreq ##1 state_ff.waitreq;
    endsequence

    property p_bus_answer;
        @(posedge clock_i) disable iff (rst_i)
            (avs_req_i.read || avs_req_i.write) && state_ff.waitreq |=> s_answer;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("waitrequest did not drop for exactly one cycle");

    property p_rd_idle;
        @(posedge clock_i) disable iff (rst_i) state_ff.waitreq |-> state_ff.rdata == RDATA_IDLE;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle outside an answer");

    property p_en_sets;
        @(posedge clock_i) disable iff (rst_i) s_wr(OFS_IRQ_EN, BIT_COMPLETE) |=> state_ff.mask[0][BIT_COMPLETE];
    endproperty
    a_en_sets: assert property (p_en_sets) else $error("enable write did not set mask");

    property p_dis_clears;
        @(posedge clock_i) disable iff (rst_i)
            s_wr(OFS_IRQ_DIS, BIT_RELOAD_ZERO) |=> !state_ff.mask[0][BIT_RELOAD_ZERO];
    endproperty
    a_dis_clears: assert property (p_dis_clears) else $error("disable write did not clear mask");

    // only the first edge after release is looked at, so the unknown state before reset never counts
    property p_mask_rst;
        @(posedge clock_i) $past(rst_i) && !rst_i |-> state_ff.mask == '0 && !state_ff.irq[0] && state_ff.err == '0;
    endproperty
    a_mask_rst: assert property (p_mask_rst) else $error("mask not zero after reset");

    property p_err_sticky;
        @(posedge clock_i) disable iff (rst_i)
            xfer_error_i[2] ##1 !error_clear_cmd_i[2] [*2] |=> state_ff.err[2];
    endproperty
    a_err_sticky: assert property (p_err_sticky) else $error("error flag lost without clear");

    property p_err_setwins;
        @(posedge clock_i) disable iff (rst_i) xfer_error_i[2] && error_clear_cmd_i[2] |=> state_ff.err[2];
    endproperty
    a_err_setwins: assert property (p_err_setwins) else $error("clear beat a new error");

    property p_err_clear;
        @(posedge clock_i) disable iff (rst_i) error_clear_cmd_i[2] && !xfer_error_i[2] |=> !state_ff.err[2];
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("clear command did not clear error");

    property p_stat_read;
        @(posedge clock_i) disable iff (rst_i)
            s_rd_stat |=> state_ff.rdata[BIT_COMPLETE] == $past(xfer_counter_zero_i[0] && xfer_counter_reload_zero_i[0])
                && state_ff.rdata[BIT_RELOAD_ZERO] == $past(xfer_counter_reload_zero_i[0]);
    endproperty
    a_stat_read: assert property (p_stat_read) else $error("status read wrong");

    property p_irq;
        @(posedge clock_i) disable iff (rst_i)
            ##1 irq_o[1] == $past((state_ff.err[1] && state_ff.mask[1][BIT_ERROR])
                || (xfer_counter_zero_i[1] && xfer_counter_reload_zero_i[1] && state_ff.mask[1][BIT_COMPLETE])
                || (xfer_counter_reload_zero_i[1] && state_ff.mask[1][BIT_RELOAD_ZERO]));
    endproperty
    a_irq: assert property (p_irq) else $error("irq does not follow status and mask");

    property p_sel0;
        @(posedge clock_i) disable iff (rst_i) wr_go && avs_req_i.address == OFS_PCTL && avs_req_i.byteenable[2]
            |=> state_ff.sel[0] == $past(avs_req_i.writedata[PC_SEL0 +: SEL_W]);
    endproperty
    a_sel0: assert property (p_sel0) else $error("monitor 0 select not stored");

    property p_res_zero;
        @(posedge clock_i) disable iff (rst_i)
            rd_take && avs_req_i.address == OFS_PCTL |=> state_ff.rdata[PC_RES1:PC_RES0] == 2'b00;
    endproperty
    a_res_zero: assert property (p_res_zero) else $error("counter reset bit read nonzero");

    property p_res1;
        @(posedge clock_i) disable iff (rst_i) res_wr[1] |=> state_ff.data[1] == '0 && state_ff.stall[1] == '0;
    endproperty
    a_res1: assert property (p_res1) else $error("monitor 1 reset left a count");

    property p_res0;
        @(posedge clock_i) disable iff (rst_i) res_wr[0] |=> state_ff.data[0] == '0 && state_ff.stall[0] == '0;
    endproperty
    a_res0: assert property (p_res0) else $error("monitor 0 reset left a count");

    property p_wrap;
        @(posedge clock_i) disable iff (rst_i) ovf[0] && !state_ff.frz[0] && !res_wr[0] |=> state_ff.data[0] == '0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("overflow did not reset monitor");

    property p_stall_wrap;
        @(posedge clock_i) disable iff (rst_i) ovf[0] && !state_ff.frz[0] && !res_wr[0] |=> state_ff.stall[0] == '0;
    endproperty
    a_stall_wrap: assert property (p_stall_wrap) else $error("overflow left a stall count");

    property p_freeze;
        @(posedge clock_i) disable iff (rst_i) ovf[1] && state_ff.frz[1] && !res_wr[1] |=> $stable(state_ff.data[1]);
    endproperty
    a_freeze: assert property (p_freeze) else $error("frozen monitor moved");

    property p_freeze_stall;
        @(posedge clock_i) disable iff (rst_i) ovf[0] && state_ff.frz[0] && !res_wr[0] |=> $stable(state_ff.stall[0]);
    endproperty
    a_freeze_stall: assert property (p_freeze_stall) else $error("frozen stall count moved");

    property p_off1;
        @(posedge clock_i) disable iff (rst_i) !state_ff.en[1] && !res_wr[1] |=> $stable(state_ff.stall[1]);
    endproperty
    a_off1: assert property (p_off1) else $error("disabled monitor 1 counted");

    property p_on0;
        @(posedge clock_i) disable iff (rst_i)
            state_ff.en[0] && data_cycle_i[1] && state_ff.sel[0] == SEL_W'(1) && !ovf[0] && !res_wr[0]
            |=> state_ff.data[0] == $past(state_ff.data[0]) + 1'b1;
    endproperty
    a_on0: assert property (p_on0) else $error("enabled monitor 0 missed a cycle");
endmodule

// ---- design/dcipm_pkg.sv ----
// package: register map, field positions and bus carrier for the channel irq and perf monitor block
package dcipm_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned CH_SHIFT = 6;
    localparam logic [5:0] OFS_IRQ_EN = 6'h20;
    localparam logic [5:0] OFS_IRQ_DIS = 6'h24;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h28;
    localparam logic [5:0] OFS_IRQ_STAT = 6'h2c;
    localparam logic [11:0] OFS_PCTL = 12'h800;
    // status and mask bit positions
    localparam int unsigned BIT_RELOAD_ZERO = 0;
    localparam int unsigned BIT_COMPLETE = 1;
    localparam int unsigned BIT_ERROR = 2;
    // perf control field positions
    localparam int unsigned PC_EN0 = 0;
    localparam int unsigned PC_EN1 = 1;
    localparam int unsigned PC_OF0 = 4;
    localparam int unsigned PC_OF1 = 5;
    localparam int unsigned PC_RES0 = 8;
    localparam int unsigned PC_RES1 = 9;
    localparam int unsigned PC_SEL0 = 16;
    localparam int unsigned PC_SEL1 = 24;
    localparam int unsigned SEL_W = 6;
    // reset values
    localparam logic [2:0] MASK_RST = 3'h0;
    localparam logic [31:0] PCTL_RST = 32'h0000_0000;
    localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;
    // avalon-mm request from the master
    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic read;
        logic write;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } dcipm_avs_req_t;
endpackage

// ---- tb/tb_top.sv ----
// testbench: register access, status flags, interrupt lines and monitor counters
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import dcipm_pkg::*;
    localparam int CW = 4;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    dcipm_avs_req_t req = '0;
    logic [3:0] err_i = '0;
    logic [3:0] clr_i = '0;
    logic [3:0] cz_i = '0;
    logic [3:0] rz_i = '0;
    logic [3:0] dc_i = '0;
    logic [3:0] sc_i = '0;
    logic wait_o;
    logic [31:0] rd_o;
    logic [3:0] irq_o;
    logic [1:0][CW-1:0] md_o;
    logic [1:0][CW-1:0] ms_o;
    logic [31:0] rv;
    logic [31:0] dv;
    int n_fail = 0;
    int samples_checked = 0;

    // small counter width so overflow is reached in a few cycles
    dcipm_top #(.NUM_CH(4), .CNT_W(CW)) i_dcipm_top (.clock_i(clock_i), .rst_i(rst_i), .avs_req_i(req),
        .xfer_error_i(err_i), .error_clear_cmd_i(clr_i), .xfer_counter_zero_i(cz_i),
        .xfer_counter_reload_zero_i(rz_i), .data_cycle_i(dc_i), .stall_cycle_i(sc_i),
        .avs_waitrequest_o(wait_o), .avs_readdata_o(rd_o), .irq_o(irq_o), .mon_data_o(md_o), .mon_stall_o(ms_o));

    always #12.5 clock_i = ~clock_i;

    //////////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // one avalon access; request held until the edge that sees waitrequest low
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clock_i);
        req.address <= a;
        req.write <= wr;
        req.read <= !wr;
        req.byteenable <= 4'hf;
        req.writedata <= d;
        // no limit here: a slave that never answers is caught by the watchdog
        do begin
            @(posedge clock_i);
        end while (wait_o !== 1'b0);
        q = rd_o;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d, dv);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000, rv);
        check(rv, exp);
    endtask

    // let the registered outputs land before looking at them
    task automatic settle(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    // traffic on channels 1 and 2 for n cycles; stall only where s says
    task automatic run(input int n, input logic [3:0] s);
        dc_i <= 4'b0110;
        sc_i <= s;
        repeat (n) @(posedge clock_i);
        dc_i <= 4'b0000;
        sc_i <= 4'b0000;
        #1;
    endtask

    //////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        rd_chk({6'd0, OFS_IRQ_MASK}, 32'h0000_0000);
        rd_chk({6'd0, OFS_IRQ_STAT}, 32'h0000_0000);
        rd_chk(OFS_PCTL, PCTL_RST);
        rd_chk(12'h03c, 32'h0000_0000);
        rd_chk(12'h7f0, 32'h0000_0000);
        // each channel: set all, clear one, then zero writes must change nothing
        for (int c = 0; c < 4; c++) begin
            wr({6'(c), OFS_IRQ_EN}, 32'h0000_0007);
            rd_chk({6'(c), OFS_IRQ_MASK}, 32'h0000_0007);
            wr({6'(c), OFS_IRQ_DIS}, 32'(1 << (c % 3)));
            rd_chk({6'(c), OFS_IRQ_MASK}, 32'h0000_0007 ^ 32'(1 << (c % 3)));
            wr({6'(c), OFS_IRQ_EN}, 32'h0000_0000);
            wr({6'(c), OFS_IRQ_DIS}, 32'h0000_0000);
            rd_chk({6'(c), OFS_IRQ_MASK}, 32'h0000_0007 ^ 32'(1 << (c % 3)));
        end
        // all four counter combinations on channel 1 (mask there is 5)
        for (int k = 0; k < 4; k++) begin
            cz_i[1] <= k[0];
            rz_i[1] <= k[1];
            rd_chk({6'd1, OFS_IRQ_STAT}, {30'h0, k[0] & k[1], k[1]});
        end
        settle(2);
        check(32'(irq_o), 32'h0000_0002);
        wr({6'd1, OFS_IRQ_DIS}, 32'h0000_0001);
        settle(2);
        check(32'(irq_o), 32'h0000_0000);
        // sticky error on channel 2, masked until enabled
        @(posedge clock_i);
        err_i[2] <= 1'b1;
        @(posedge clock_i);
        err_i[2] <= 1'b0;
        rd_chk({6'd2, OFS_IRQ_STAT}, 32'h0000_0004);
        rd_chk({6'd2, OFS_IRQ_STAT}, 32'h0000_0004);
        settle(2);
        check(32'(irq_o), 32'h0000_0000);
        wr({6'd2, OFS_IRQ_EN}, 32'h0000_0004);
        settle(2);
        check(32'(irq_o), 32'h0000_0004);
        // error and clear in one cycle: the error must win
        @(posedge clock_i);
        err_i[2] <= 1'b1;
        clr_i[2] <= 1'b1;
        @(posedge clock_i);
        err_i[2] <= 1'b0;
        clr_i[2] <= 1'b0;
        rd_chk({6'd2, OFS_IRQ_STAT}, 32'h0000_0004);
        @(posedge clock_i);
        clr_i[2] <= 1'b1;
        @(posedge clock_i);
        clr_i[2] <= 1'b0;
        rd_chk({6'd2, OFS_IRQ_STAT}, 32'h0000_0000);
        settle(2);
        check(32'(irq_o), 32'h0000_0000);
        // monitor 0 on channel 1, monitor 1 on channel 2 freezing; reset bits read zero
        wr(OFS_PCTL, 32'h0201_0323);
        rd_chk(OFS_PCTL, 32'h0201_0023);
        run(5, 4'b0010);
        check(32'(md_o[0]), 32'h0000_0005);
        check(32'(md_o[1]), 32'h0000_0005);
        check(32'(ms_o[0]), 32'h0000_0005);
        check(32'(ms_o[1]), 32'h0000_0000);
        wr(OFS_PCTL, 32'h0201_0021);
        run(5, 4'b0000);
        check(32'(md_o[0]), 32'h0000_000a);
        check(32'(md_o[1]), 32'h0000_0005);
        wr(OFS_PCTL, 32'h0201_0022);
        run(3, 4'b0000);
        check(32'(md_o[0]), 32'h0000_000a);
        check(32'(md_o[1]), 32'h0000_0008);
        // monitor 0 wraps and clears its stall count, monitor 1 holds at all ones
        wr(OFS_PCTL, 32'h0201_0023);
        run(11, 4'b0000);
        check(32'(md_o[0]), 32'h0000_0005);
        check(32'(ms_o[0]), 32'h0000_0000);
        check(32'(md_o[1]), 32'h0000_000f);
        wr(OFS_PCTL, 32'h0201_0123);
        #1;
        check(32'(md_o[0]), 32'h0000_0000);
        check(32'(md_o[1]), 32'h0000_000f);
        wr(OFS_PCTL, 32'h0201_0223);
        #1;
        check(32'(md_o[1]), 32'h0000_0000);
        // monitor 0 freezes at all ones, then monitor 1 points past the last channel and sees nothing
        wr(OFS_PCTL, 32'h0201_0031);
        run(16, 4'b0010);
        check(32'(md_o[0]), 32'h0000_000f);
        check(32'(ms_o[0]), 32'h0000_000f);
        check(32'(md_o[1]), 32'h0000_0000);
        wr(OFS_PCTL, 32'h0601_0302);
        rd_chk(OFS_PCTL, 32'h0601_0002);
        run(3, 4'b0000);
        check(32'(md_o[0]), 32'h0000_0000);
        check(32'(md_o[1]), 32'h0000_0000);
        report_and_stop();
    end

    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clock_i);
        n_fail++;
        report_and_stop();
    end
endmodule
